// ### hdl/tile_slice.sv
/*
  Bus-facing slice of one programmable digital tile: two byte queues,
  control and status registers, carry/shift holding, pin synchronizers.
  Assumes a plain register port master and an ALU/logic array outside.
*/
// Notes on behaviour
// - Two independent four-byte queues per datapath.
// - Each queue set as input or output.
// - Queue status selectable onto routing outputs.
// - Carries, shift, conditions chain to neighbours.
// - Carry and shift held, reselectable next cycle.
// - Six routing inputs and six outputs.
// - Routing inputs pick configuration and serial data.
// - Outputs chosen from conditions and serial data.
// - Bus-written control bits drive routing.
// - Read-only status returns routing signals.
// - Each control/status bit separately routed.
// - Sticky status held until read clears.
// - Control bit usable as tile clock enable.
// - Each subcomponent has own clock selection.
// - Pin port has twenty routing connections.
// - Optional output pipeline, input double sync.
// - Pin synchronizers run on system clock.
// - Queues feed or capture accumulators, ALU.
// - Queue entries are eight bits wide.
`timescale 1ns/1ps
`include "tile_cfg.svh"
module tile_slice (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic [5:0] route_in_i,
  output logic [5:0] route_out_o,
  output logic [2:0] cfg_addr_o,
  output logic [2:0] serial_in_o,
  input wire logic [7:0] acc0_i,
  input wire logic [7:0] acc1_i,
  input wire logic [7:0] alu_i,
  input wire logic [5:0] cond_i,
  input wire logic [1:0] serial_out_i,
  input wire logic dp_q0_rd_i,
  input wire logic dp_q1_rd_i,
  input wire logic dp_q0_wr_i,
  input wire logic dp_q1_wr_i,
  output logic [7:0] q0_head_o,
  output logic [7:0] q1_head_o,
  output logic [3:0] q_status_o,
  input wire logic carry_i,
  input wire logic shift_i,
  input wire logic chain_carry_i,
  input wire logic chain_shift_i,
  input wire logic chain_cond_i,
  output logic chain_carry_o,
  output logic chain_shift_o,
  output logic chain_cond_o,
  output logic carry_sel_o,
  output logic shift_sel_o,
  input wire logic [7:0] status_route_i,
  output logic [7:0] ctrl_route_o,
  output logic [3:0] clk_en_o,
  input wire logic [7:0] pin_in_i,
  input wire logic [7:0] pin_out_i,
  output logic [7:0] pin_in_route_o,
  output logic [7:0] pin_out_o,
  input wire logic [3:0] pin_drive_i,
  output logic [3:0] pin_drive_o
);

  // Registers written by software, plus sticky status and read data
  logic [7:0] qcfg_reg;
  logic [7:0] ctrl_reg;
  logic [7:0] sticky_en_reg;
  logic [7:0] clk_sel_reg;
  logic [7:0] out_sel_reg;
  logic [7:0] pin_cfg_reg;
  logic [7:0] chain_reg;
  logic [7:0] sticky_reg;
  logic [7:0] rdata_reg;

  // Per-queue state, indexed 0/1
  tile_pkg::word_t mem_reg [2][4];
  tile_pkg::qptr_t wp_reg [2];
  tile_pkg::qptr_t rp_reg [2];
  tile_pkg::qcnt_t cnt_reg [2];
  logic [1:0] q_empty;
  logic [1:0] q_full;
  logic [1:0] q_push;
  logic [1:0] q_pop;
  tile_pkg::word_t q_din [2];

  // Software-side strobes
  logic bus_rd_q0;
  logic bus_rd_q1;
  logic bus_wr_q0;
  logic bus_wr_q1;
  assign bus_rd_q0 = rd_i && (addr_i == `ADDR_Q0_DATA);
  assign bus_rd_q1 = rd_i && (addr_i == `ADDR_Q1_DATA);
  assign bus_wr_q0 = wr_i && (addr_i == `ADDR_Q0_DATA);
  assign bus_wr_q1 = wr_i && (addr_i == `ADDR_Q1_DATA);

  // Direction: 0 = input buffer (bus fills), 1 = output buffer (datapath fills)
  logic [1:0] q_dir;
  assign q_dir = {qcfg_reg[`QCFG_Q1_DIR], qcfg_reg[`QCFG_Q0_DIR]};

  // Capture source for output-buffer mode
  function automatic tile_pkg::word_t pick_src(input logic [1:0] sel);
    tile_pkg::word_t v;
    v = `RST_ZERO8;
    unique case (tile_pkg::qsrc_e'(sel))
      tile_pkg::SRC_ACC0: v = acc0_i;
      tile_pkg::SRC_ACC1: v = acc1_i;
      tile_pkg::SRC_ALU: v = alu_i;
      tile_pkg::SRC_ROUTE: v = status_route_i;
    endcase
    return v;
  endfunction : pick_src

  // Push/pop steering per direction; illegal accesses are dropped
  always_comb begin
    q_push[0] = q_dir[0] ? dp_q0_wr_i : bus_wr_q0;
    q_push[1] = q_dir[1] ? dp_q1_wr_i : bus_wr_q1;
    q_pop[0] = q_dir[0] ? bus_rd_q0 : dp_q0_rd_i;
    q_pop[1] = q_dir[1] ? bus_rd_q1 : dp_q1_rd_i;
    q_din[0] = q_dir[0] ? pick_src(qcfg_reg[`QCFG_Q0_SRC_LO +: 2]) : wdata_i;
    q_din[1] = q_dir[1] ? pick_src(qcfg_reg[`QCFG_Q1_SRC_LO +: 2]) : wdata_i;
  end

  // Two identical four-entry byte queues
  genvar gq;
  generate
    for (gq = 0; gq < 2; gq++) begin : g_queue
      logic do_push;
      logic do_pop;
      assign q_empty[gq] = (cnt_reg[gq] == 3'h0);
      assign q_full[gq] = (cnt_reg[gq] == `FIFO_DEPTH);
      assign do_push = q_push[gq] && !q_full[gq];
      assign do_pop = q_pop[gq] && !q_empty[gq];

      // Storage is flops; no reset needed on data but kept for clean reads
      always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
          for (int e = 0; e < 4; e++) begin
            mem_reg[gq][e] <= `RST_ZERO8;
          end
        end else if (do_push) begin
          mem_reg[gq][wp_reg[gq]] <= q_din[gq];
        end
      end

      // Pointers and occupancy
      always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
          wp_reg[gq] <= 2'h0;
          rp_reg[gq] <= 2'h0;
          cnt_reg[gq] <= 3'h0;
        end else begin
          if (do_push) begin
            wp_reg[gq] <= wp_reg[gq] + 2'h1;
          end
          if (do_pop) begin
            rp_reg[gq] <= rp_reg[gq] + 2'h1;
          end
          if (do_push && !do_pop) begin
            cnt_reg[gq] <= cnt_reg[gq] + 3'h1;
          end else if (do_pop && !do_push) begin
            cnt_reg[gq] <= cnt_reg[gq] - 3'h1;
          end
        end
      end
    end
  endgenerate

  // Head bytes toward the datapath loads (data and accumulator registers)
  assign q0_head_o = mem_reg[0][rp_reg[0]];
  assign q1_head_o = mem_reg[1][rp_reg[1]];
  assign q_status_o = {q_full[1], q_empty[1], q_full[0], q_empty[0]};

  // Routing inputs: low three pick configuration, upper three serial data
  assign cfg_addr_o = route_in_i[2:0];
  assign serial_in_o = route_in_i[5:3];

  // Output pool: six conditions, two serial outs, four queue status bits
  // Top four slots unused; padded so every selector index stays in range
  logic [15:0] out_pool;
  assign out_pool = {4'h0, q_status_o, serial_out_i, cond_i};
  logic [5:0] route_out_next;
  always_comb begin
    for (int k = 0; k < 6; k++) begin
      // Selector: bit k of out_sel picks upper half of a pair of candidates
      route_out_next[k] = out_sel_reg[k] ? out_pool[(k + 6) & 15] : out_pool[k];
    end
  end
  // Registered routing outputs keep glitches off long fabric wires
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      route_out_o <= 6'h00;
    end else begin
      route_out_o <= route_out_next;
    end
  end

  // Carry/shift holding for time multiplexing and chaining
  logic carry_hold_reg;
  logic shift_hold_reg;
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      carry_hold_reg <= 1'b0;
      shift_hold_reg <= 1'b0;
    end else begin
      carry_hold_reg <= carry_i;
      shift_hold_reg <= shift_i;
    end
  end
  always_comb begin
    if (chain_reg[`CHAIN_TMUX_BIT]) begin
      carry_sel_o = carry_hold_reg;
      shift_sel_o = shift_hold_reg;
    end else if (chain_reg[`CHAIN_EN_BIT]) begin
      carry_sel_o = chain_carry_i;
      shift_sel_o = chain_shift_i;
    end else begin
      carry_sel_o = 1'b0;
      shift_sel_o = 1'b0;
    end
  end
  // Neighbour chain outputs gated so an unchained tile stays quiet
  assign chain_carry_o = chain_reg[`CHAIN_EN_BIT] & carry_i;
  assign chain_shift_o = chain_reg[`CHAIN_EN_BIT] & shift_i;
  assign chain_cond_o = chain_reg[`CHAIN_EN_BIT] & (cond_i[0] | chain_cond_i);

  // Control bits drive the fabric, each on its own wire
  assign ctrl_route_o = ctrl_reg;
  // Clock enables: sel bit n+4 is enable n; sel bit n makes ctrl bit 7 gate it
  genvar gc;
  generate
    for (gc = 0; gc < 4; gc++) begin : g_clk
      assign clk_en_o[gc] = clk_sel_reg[gc] ? (ctrl_reg[7] & clk_sel_reg[gc + 4])
                                            : clk_sel_reg[gc + 4];
    end
  endgenerate

  // Sticky status: set wins over read clear
  logic stat_read;
  assign stat_read = rd_i && (addr_i == `ADDR_STATUS);
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sticky_reg <= `RST_ZERO8;
    end else begin
      for (int b = 0; b < 8; b++) begin
        if (sticky_en_reg[b] && status_route_i[b]) begin
          sticky_reg[b] <= 1'b1;
        end else if (stat_read) begin
          sticky_reg[b] <= 1'b0;
        end
      end
    end
  end
  logic [7:0] status_view;
  always_comb begin
    for (int b = 0; b < 8; b++) begin
      status_view[b] = sticky_en_reg[b] ? sticky_reg[b] : status_route_i[b];
    end
  end

  // Pin port: 8 in, 8 out, 4 drive = twenty routes; cfg bit0 sync, bit1 pipe
  logic [7:0] pin_s1_reg;
  logic [7:0] pin_s2_reg;
  logic [7:0] pin_pipe_reg;
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pin_s1_reg <= `RST_ZERO8;
      pin_s2_reg <= `RST_ZERO8;
      pin_pipe_reg <= `RST_ZERO8;
    end else begin
      pin_s1_reg <= pin_in_i;
      pin_s2_reg <= pin_s1_reg;
      pin_pipe_reg <= pin_out_i;
    end
  end
  // Bypass exists for pin-to-pin feedthrough only; CPU paths need sync on
  assign pin_in_route_o = pin_cfg_reg[0] ? pin_s2_reg : pin_in_i;
  assign pin_out_o = pin_cfg_reg[1] ? pin_pipe_reg : pin_out_i;
  assign pin_drive_o = pin_drive_i;

  // Configuration register writes
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      qcfg_reg <= `RST_ZERO8;
      ctrl_reg <= `RST_ZERO8;
      sticky_en_reg <= `RST_ZERO8;
      clk_sel_reg <= `RST_ZERO8;
      out_sel_reg <= `RST_ZERO8;
      pin_cfg_reg <= `RST_ZERO8;
      chain_reg <= `RST_ZERO8;
    end else if (wr_i) begin
      unique case (addr_i)
        `ADDR_Q_CFG: qcfg_reg <= wdata_i;
        `ADDR_CTRL: ctrl_reg <= wdata_i;
        `ADDR_STAT_STICKY: sticky_en_reg <= wdata_i;
        `ADDR_CLK_SEL: clk_sel_reg <= wdata_i;
        `ADDR_OUT_SEL: out_sel_reg <= wdata_i;
        `ADDR_PIN_CFG: pin_cfg_reg <= wdata_i;
        `ADDR_CHAIN_CFG: chain_reg <= wdata_i;
        default: ;
      endcase
    end
  end

  // Read data one cycle later; status register ignores writes
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata_reg <= `RST_ZERO8;
    end else if (rd_i) begin
      unique case (addr_i)
        `ADDR_Q0_DATA: rdata_reg <= q_dir[0] ? mem_reg[0][rp_reg[0]] : `RST_ZERO8;
        `ADDR_Q1_DATA: rdata_reg <= q_dir[1] ? mem_reg[1][rp_reg[1]] : `RST_ZERO8;
        `ADDR_Q_CFG: rdata_reg <= qcfg_reg;
        `ADDR_CTRL: rdata_reg <= ctrl_reg;
        `ADDR_STATUS: rdata_reg <= status_view;
        `ADDR_STAT_STICKY: rdata_reg <= sticky_en_reg;
        `ADDR_CLK_SEL: rdata_reg <= clk_sel_reg;
        `ADDR_OUT_SEL: rdata_reg <= out_sel_reg;
        `ADDR_PIN_CFG: rdata_reg <= pin_cfg_reg;
        `ADDR_CHAIN_CFG: rdata_reg <= chain_reg;
        `ADDR_QSTAT: rdata_reg <= {4'h0, q_status_o};
        default: rdata_reg <= `RST_ZERO8;
      endcase
    end else begin
      rdata_reg <= `RST_ZERO8;
    end
  end
  assign rdata_o = rdata_reg;

endmodule : tile_slice

// ### common/tile_cfg.svh
/*
  Offsets, field positions, reset values and sizes for the digital tile slice.
  Assumes inclusion by bare name from package and design files.
*/
`ifndef TILE_CFG_SVH
`define TILE_CFG_SVH
`define FIFO_DEPTH 3'h4
`define WORD_W 8
`define ROUTE_W 6
`define PIN_W 8
// Register indices on the plain port
`define ADDR_Q0_DATA 4'h0
`define ADDR_Q1_DATA 4'h1
`define ADDR_Q_CFG 4'h2
`define ADDR_CTRL 4'h3
`define ADDR_STATUS 4'h4
`define ADDR_STAT_STICKY 4'h5
`define ADDR_CLK_SEL 4'h6
`define ADDR_OUT_SEL 4'h7
`define ADDR_PIN_CFG 4'h8
`define ADDR_CHAIN_CFG 4'h9
`define ADDR_QSTAT 4'hA
// Queue and chain config fields, zero reset value
`define QCFG_Q0_DIR 0
`define QCFG_Q1_DIR 1
`define QCFG_Q0_SRC_LO 2
`define QCFG_Q1_SRC_LO 4
`define CHAIN_EN_BIT 0
`define CHAIN_TMUX_BIT 1
`define RST_ZERO8 8'h00
`endif

// ### common/tile_pkg.sv
/*
  Types for the digital tile slice.
  Assumes tile_cfg.svh holds the numbers.
*/
`include "tile_cfg.svh"
package tile_pkg;
  typedef logic [`WORD_W-1:0] word_t;
  typedef logic [1:0] qptr_t;
  typedef logic [2:0] qcnt_t;
  // Queue capture source in output-buffer mode
  typedef enum logic [1:0] {
    SRC_ACC0 = 2'h0,
    SRC_ACC1 = 2'h1,
    SRC_ALU = 2'h2,
    SRC_ROUTE = 2'h3
  } qsrc_e;
endpackage : tile_pkg

// ### sim/tile_slice_properties.sv
/*
  Port checker for tile_slice, bound to every instance.
  Assumes bus writes decode as in tile_cfg.svh.
*/
`timescale 1ns/1ps
`include "tile_cfg.svh"
module tile_slice_checker (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic [5:0] route_in_i,
  input wire logic [2:0] cfg_addr_o,
  input wire logic [2:0] serial_in_o,
  input wire logic dp_q0_rd_i,
  input wire logic [3:0] q_status_o,
  input wire logic carry_i,
  input wire logic chain_carry_o,
  input wire logic [7:0] ctrl_route_o,
  input wire logic [7:0] pin_in_i,
  input wire logic [7:0] pin_in_route_o,
  input wire logic [3:0] pin_drive_i,
  input wire logic [3:0] pin_drive_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  logic [7:0] qcfg_reg, pin_reg, chain_reg;
  // Shadow copies of config writes, since registers are hidden
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      qcfg_reg <= 8'h00;
      pin_reg <= 8'h00;
      chain_reg <= 8'h00;
    end else if (wr_i) begin
      if (addr_i == `ADDR_Q_CFG) qcfg_reg <= wdata_i;
      if (addr_i == `ADDR_PIN_CFG) pin_reg <= wdata_i;
      if (addr_i == `ADDR_CHAIN_CFG) chain_reg <= wdata_i;
    end
  end
  route_sel_a: assert property ({serial_in_o, cfg_addr_o} == route_in_i)
    else $error("routing select wrong");
  ctrl_drive_a: assert property (wr_i && addr_i == `ADDR_CTRL |=>
    ctrl_route_o == $past(wdata_i)) else $error("control bits not driven");
  drive_pass_a: assert property (pin_drive_o == pin_drive_i)
    else $error("drive strength lost");
  // Two stages exactly; one stage would be a metastability hazard
  pin_sync_a: assert property (pin_reg[0] && $past(pin_reg[0], 2) |->
    pin_in_route_o == $past(pin_in_i, 2)) else $error("pin sync depth wrong");
  flag_excl_a: assert property (!(&q_status_o[1:0]) && !(&q_status_o[3:2]))
    else $error("queue both full and empty");
  fill_clear_a: assert property (!qcfg_reg[0] && q_status_o[0] && wr_i &&
    addr_i == `ADDR_Q0_DATA |=> !q_status_o[0]) else $error("empty not cleared");
  full_hold_a: assert property (!qcfg_reg[0] && q_status_o[1] && !dp_q0_rd_i
    |=> q_status_o[1]) else $error("full queue changed");
  chain_out_a: assert property (chain_carry_o == (chain_reg[0] & carry_i))
    else $error("chain carry wrong");
  cover property (q_status_o[1]);
  cover property (wr_i && addr_i == `ADDR_CTRL);
  cover property (pin_reg[0] && pin_in_i != 8'h00);
endmodule : tile_slice_checker
bind tile_slice tile_slice_checker chk (.clk_i, .reset_n_i, .addr_i, .wdata_i, .wr_i,
  .route_in_i, .cfg_addr_o, .serial_in_o, .dp_q0_rd_i, .q_status_o, .carry_i,
  .chain_carry_o, .ctrl_route_o, .pin_in_i, .pin_in_route_o, .pin_drive_i, .pin_drive_o);

// ### sim/dp_model.sv
/*
  Datapath-side stand-in: capture sources, conditions, neighbour chain.
  Assumes the slice samples these on the rising clock edge.
*/
`timescale 1ns/1ps
module dp_model (
  input wire logic clk_i,
  input wire logic reset_n_i,
  output logic [7:0] acc0_o,
  output logic [7:0] acc1_o,
  output logic [7:0] alu_o,
  output logic [5:0] cond_o,
  output logic [1:0] serial_o,
  output logic carry_o,
  output logic shift_o,
  output logic [2:0] nbr_o
);
  logic [7:0] cnt_reg;
  // Pattern moves every cycle so stale captures show up
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt_reg <= 8'h00;
    end else begin
      cnt_reg <= cnt_reg + 8'h13;
    end
  end
  // Accumulator and ALU values for output-mode queues
  assign acc0_o = cnt_reg;
  assign acc1_o = ~cnt_reg;
  assign alu_o = {cnt_reg[3:0], cnt_reg[7:4]};
  assign cond_o = cnt_reg[5:0];
  assign serial_o = cnt_reg[7:6];
  assign carry_o = cnt_reg[0];
  assign shift_o = cnt_reg[1];
  assign nbr_o = cnt_reg[4:2];
endmodule : dp_model

// ### sim/tile_slice_bench.sv
/*
  Self-checking bench for tile_slice with the datapath stand-in.
  Assumes the plain register port and one 10 MHz clock.
*/
`timescale 1ns/1ps
`include "tile_cfg.svh"
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin errors++; \
  $display("[FAIL] %s exp %h got %h", n, e, s); end end
module tile_slice_bench;
  logic clk_i = 1'b0, reset_n_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
  logic dp_q0_rd_i = 1'b0, dp_q1_wr_i = 1'b0, dp_q1_rd_i = 1'b0, dp_q0_wr_i = 1'b0;
  logic [3:0] addr_i = 4'h0, pin_drive_i = 4'h0;
  logic [7:0] wdata_i = 8'h00, status_route_i = 8'h00, pin_in_i = 8'h00, pin_out_i = 8'h00;
  logic [5:0] route_in_i = 6'h00;
  logic [7:0] rdata_o, acc0_i, acc1_i, alu_i, q0_head_o, q1_head_o;
  logic [7:0] ctrl_route_o, pin_in_route_o, pin_out_o;
  logic [5:0] route_out_o, cond_i;
  logic [3:0] q_status_o, clk_en_o, pin_drive_o;
  logic [2:0] cfg_addr_o, serial_in_o, nbr;
  logic [1:0] serial_out_i, held;
  logic carry_i, shift_i, chain_carry_o, chain_shift_o, chain_cond_o, carry_sel_o, shift_sel_o;
  int errors = 0, compares = 0, cycles = 0;
  logic [7:0] exp_q [$];
  tile_slice dut (.clk_i, .reset_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .route_in_i, .route_out_o, .cfg_addr_o, .serial_in_o, .acc0_i, .acc1_i, .alu_i,
    .cond_i, .serial_out_i, .dp_q0_rd_i, .dp_q1_rd_i, .dp_q0_wr_i,
    .dp_q1_wr_i, .q0_head_o, .q1_head_o, .q_status_o, .carry_i, .shift_i,
    .chain_carry_i(nbr[0]), .chain_shift_i(nbr[1]), .chain_cond_i(nbr[2]),
    .chain_carry_o, .chain_shift_o, .chain_cond_o, .carry_sel_o, .shift_sel_o,
    .status_route_i, .ctrl_route_o, .clk_en_o, .pin_in_i, .pin_out_i,
    .pin_in_route_o, .pin_out_o, .pin_drive_i, .pin_drive_o);
  dp_model dpm (.clk_i, .reset_n_i, .acc0_o(acc0_i), .acc1_o(acc1_i), .alu_o(alu_i),
    .cond_o(cond_i), .serial_o(serial_out_i), .carry_o(carry_i), .shift_o(shift_i),
    .nbr_o(nbr));
  // 100 ns period
  initial begin
    forever #50 clk_i = ~clk_i;
  end
  task automatic stop_test();
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : stop_test
  // Hang guard, well above the run length of about 110 cycles
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      stop_test();
    end
  end
  task automatic bus_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    #10;
  endtask : bus_wr
  // Read data stands only in the cycle after the strobe
  task automatic bus_rd(input logic [3:0] a, input logic [7:0] e, input string n);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #10 `CHK(n, e, rdata_o)
  endtask : bus_rd
  initial begin
    repeat (20) @(posedge clk_i);
    reset_n_i <= 1'b1;
    route_in_i <= 6'h2B;
    #10 `CHK("reset status", 4'h5, q_status_o)
    `CHK("route cfg", 6'h2B, {serial_in_o, cfg_addr_o})
    for (int i = 0; i < 4; i++) bus_wr(`ADDR_Q0_DATA, 8'h10 + i);
    `CHK("q0 full", 1'b1, q_status_o[1])
    bus_wr(`ADDR_Q0_DATA, 8'hEE);
    bus_rd(`ADDR_Q0_DATA, 8'h00, "q0 bus read");
    for (int i = 0; i < 4; i++) begin
      `CHK("q0 head", 8'h10 + i, q0_head_o)
      @(posedge clk_i);
      dp_q0_rd_i <= 1'b1;
      @(posedge clk_i);
      dp_q0_rd_i <= 1'b0;
      #10;
    end
    `CHK("q0 empty", 1'b1, q_status_o[0])
    bus_wr(`ADDR_Q_CFG, 8'h02);
    // Expected byte taken while it stands, before the capturing edge
    for (int i = 0; i < 3; i++) begin
      @(posedge clk_i);
      dp_q1_wr_i <= 1'b1;
      #10 exp_q.push_back(acc0_i);
      @(posedge clk_i);
      dp_q1_wr_i <= 1'b0;
    end
    for (int i = 0; i < 3; i++) bus_rd(`ADDR_Q1_DATA, exp_q.pop_front(), "q1 data");
    bus_wr(`ADDR_Q1_DATA, 8'h55);
    `CHK("q1 empty", 1'b1, q_status_o[2])
    // Swap roles: queue 0 captures the ALU, queue 1 is filled by the bus
    bus_wr(`ADDR_Q_CFG, 8'h09);
    @(posedge clk_i);
    dp_q0_wr_i <= 1'b1;
    #10 exp_q.push_back(alu_i);
    @(posedge clk_i);
    dp_q0_wr_i <= 1'b0;
    bus_wr(`ADDR_Q1_DATA, 8'h77);
    `CHK("q1 head", 8'h77, q1_head_o)
    bus_rd(`ADDR_Q0_DATA, exp_q.pop_front(), "q0 alu data");
    @(posedge clk_i);
    dp_q1_rd_i <= 1'b1;
    @(posedge clk_i);
    dp_q1_rd_i <= 1'b0;
    #10 `CHK("both empty", 4'h5, q_status_o)
    bus_wr(`ADDR_CTRL, 8'hA5);
    `CHK("ctrl route", 8'hA5, ctrl_route_o)
    bus_wr(`ADDR_STATUS, 8'hFF);
    @(posedge clk_i);
    status_route_i <= 8'h3C;
    bus_rd(`ADDR_STATUS, 8'h3C, "status");
    bus_rd(4'hF, 8'h00, "unmapped");
    bus_wr(`ADDR_STAT_STICKY, 8'h01);
    @(posedge clk_i);
    status_route_i <= 8'h01;
    @(posedge clk_i);
    status_route_i <= 8'h00;
    bus_rd(`ADDR_STATUS, 8'h01, "sticky held");
    bus_rd(`ADDR_STATUS, 8'h00, "sticky cleared");
    bus_wr(`ADDR_CLK_SEL, 8'hF1);
    @(posedge clk_i);
    #10 `CHK("clk en on", 4'hF, clk_en_o)
    bus_wr(`ADDR_CTRL, 8'h25);
    @(posedge clk_i);
    #10 `CHK("clk en gated", 4'hE, clk_en_o)
    bus_wr(`ADDR_OUT_SEL, 8'h3F);
    repeat (2) @(posedge clk_i);
    #10 `CHK("route status", 4'h5, route_out_o[5:2])
    bus_wr(`ADDR_CHAIN_CFG, 8'h01);
    `CHK("chain carry in", nbr[0], carry_sel_o)
    `CHK("chain shift out", shift_i, chain_shift_o)
    // Carry toggles every cycle in the stand-in, so a live path would miss
    bus_wr(`ADDR_CHAIN_CFG, 8'h02);
    held = {shift_i, carry_i};
    @(posedge clk_i);
    #10 `CHK("time mux hold", held, {shift_sel_o, carry_sel_o})
    bus_wr(`ADDR_PIN_CFG, 8'h01);
    @(posedge clk_i);
    pin_in_i <= 8'h5A;
    pin_drive_i <= 4'h9;
    @(posedge clk_i);
    #10 `CHK("pin stage one", 8'h00, pin_in_route_o)
    @(posedge clk_i);
    #10 `CHK("pin synced", 8'h5A, pin_in_route_o)
    `CHK("pin drive", 4'h9, pin_drive_o)
    bus_wr(`ADDR_PIN_CFG, 8'h02);
    `CHK("pin raw", 8'h5A, pin_in_route_o)
    @(posedge clk_i);
    pin_out_i <= 8'hC3;
    #10 `CHK("pin out staged", 8'h00, pin_out_o)
    @(posedge clk_i);
    #10 `CHK("pin out piped", 8'hC3, pin_out_o)
    stop_test();
  end
endmodule : tile_slice_bench
